// ==== common/ulsc_pkg.sv ====
package ulsc_pkg;
	// Bit-clock rates as seen by the 125 MHz reference clock
	localparam int          REF_CLK_HZ     = 125000000;
	localparam int          FS_BIT_HZ      = 12000000;
	localparam int          LS_BIT_HZ      = 1500000;
	// Cycles per bit time, rounded down (shortest time) and never below one
	localparam int          FS_BIT_CYC_RAW = REF_CLK_HZ / FS_BIT_HZ;
	localparam int          LS_BIT_CYC_RAW = REF_CLK_HZ / LS_BIT_HZ;
	localparam int          FS_BIT_CYC     = (FS_BIT_CYC_RAW < 1) ? 1 : FS_BIT_CYC_RAW;
	localparam int          LS_BIT_CYC     = (LS_BIT_CYC_RAW < 1) ? 1 : LS_BIT_CYC_RAW;
	localparam int          CNT_W          = 8;
	// End-of-packet shape in bit times
	localparam int          EOP_SE0_BITS   = 2;
	localparam int          EOP_J_BITS     = 1;
	localparam int          RX_SE0_MIN_BITS = 1;
	// Line symbols {dp, dm}
	localparam logic [1:0]  LINE_SE0       = 2'h0;
	localparam logic [1:0]  LINE_DIFF0     = 2'h1;
	localparam logic [1:0]  LINE_DIFF1     = 2'h2;
	localparam logic [1:0]  LINE_SE1       = 2'h3;
endpackage

// ==== src/ulsc_bit_timer.sv ====
`timescale 1ns/1ps
module ulsc_bit_timer
	import ulsc_pkg::*;
#(
	parameter int CNT_W_P = CNT_W
)(
	input  wire logic               i_ref_clk,   // Reference clock
	input  wire logic               i_reset_n,   // Synchronous reset, active low
	input  wire logic               i_restart,   // Restart the bit period
	input  wire logic [CNT_W_P-1:0] i_period,    // Cycles per bit time
	output logic                    o_bit_tick   // Pulse at end of each bit time
);
	typedef struct packed {
		logic [CNT_W_P-1:0] cnt;
		logic               tick;
	} ulsc_tmr_t;

	ulsc_tmr_t st_reg;
	ulsc_tmr_t st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (i_restart)
		begin
			st_next.cnt = '0;
		end
		else if (st_reg.cnt >= i_period - CNT_W_P'(1))
		begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + CNT_W_P'(1);
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_bit_tick = st_reg.tick;
endmodule // ulsc_bit_timer

// ==== src/ulsc_line_state.sv ====
// Operation
// - Transmitted EOP single-ended zero is timed in bit times of the current transmit speed.
// - Received EOP single-ended zero is judged in bit times of this port's own device type.
// - The trailing J after EOP lasts one low-speed bit for low-speed drivers, one full-speed bit otherwise.
// - Keep-alive is sent and recognised as an EOP with low-speed timing.
// - Received Idle decodes as J and Resume decodes as K.
// - Low-speed conventions invert the J/K mapping onto differential one and zero.
// - Data, idle and resume polarity follow the speed type of the attached device; with i_hs_mode set the code keeps full-speed polarity.
// - With a full-speed device attached, full-speed polarity holds even at the low-speed rate.
// - Low-speed polarity applies only on a segment directly attached to a low-speed device.
// - A sent EOP is two bit times of single-ended zero followed by one bit time of J.
// - Start-of-packet is recognised when the line moves from Idle to K.
`timescale 1ns/1ps
module ulsc_line_state
	import ulsc_pkg::*;
(
	input  wire logic       i_ref_clk,        // Reference clock, 125 MHz
	input  wire logic       i_reset_n,        // Synchronous reset, active low
	input  wire logic       i_dp,             // D+ receiver pin
	input  wire logic       i_dm,             // D- receiver pin
	input  wire logic       i_ls_attached,    // Attached device is low-speed (pin level)
	input  wire logic       i_hs_mode,        // Port runs high-speed
	input  wire logic       i_tx_ls_rate,     // Transmit at low-speed rate
	input  wire logic       i_send_eop,       // Pulse: send end-of-packet
	input  wire logic       i_send_keepalive, // Pulse: send keep-alive
	output logic            o_tx_dp,          // D+ drive value
	output logic            o_tx_dm,          // D- drive value
	output logic            o_tx_oe,          // Line drive enable, high while driving
	output logic            o_tx_busy,        // EOP or keep-alive in progress
	output logic            o_rx_j,           // Line shows J (or Idle)
	output logic            o_rx_k,           // Line shows K (or Resume)
	output logic            o_rx_se0,         // Line shows single-ended zero
	output logic            o_rx_sop,         // Pulse: start-of-packet seen
	output logic            o_rx_eop,         // Pulse: end-of-packet seen
	output logic            o_rx_keepalive,   // Pulse: keep-alive seen
	output logic            o_ls_polarity     // Low-speed polarity in force
);
	typedef enum logic [1:0] {
		ULSC_IDLE = 2'h0,
		ULSC_SE0  = 2'h1,
		ULSC_J    = 2'h2
	} ulsc_tx_st_t;

	typedef struct packed {
		logic [1:0]       dp_sync;
		logic [1:0]       dm_sync;
		logic [1:0]       ls_sync;
		ulsc_tx_st_t      tx_st;
		logic [CNT_W-1:0] tx_cnt;
		logic             tx_ls;
		logic [CNT_W-1:0] se0_cnt;
		logic             se0_ok;
		logic             se0_ls;
		logic             was_idle;
		logic             tx_dp;
		logic             tx_dm;
		logic             tx_oe;
		logic             tx_busy;
		logic             rx_j;
		logic             rx_k;
		logic             rx_se0;
		logic             rx_sop;
		logic             rx_eop;
		logic             rx_ka;
		logic             ls_pol;
	} ulsc_state_t;

	ulsc_state_t      st_reg;
	ulsc_state_t      st_next;
	logic             tick;
	logic             restart;
	logic [CNT_W-1:0] period;
	logic [1:0]       line;
	logic             pol;
	logic             j_lvl;
	logic [CNT_W-1:0] own_bit;

	// Low-speed attach flag is synchronised like any pin; first stage read only by the second
	assign pol     = st_reg.ls_sync[1] & ~i_hs_mode;
	// J sits on differential one in FS/HS, differential zero in LS
	assign j_lvl   = ~pol;
	assign line    = {st_reg.dp_sync[1], st_reg.dm_sync[1]};
	assign period  = st_reg.tx_ls ? CNT_W'(LS_BIT_CYC) : CNT_W'(FS_BIT_CYC);
	assign own_bit = pol ? CNT_W'(LS_BIT_CYC) : CNT_W'(FS_BIT_CYC);
	assign restart = (st_reg.tx_st == ULSC_IDLE);

	ulsc_bit_timer #(
		.CNT_W_P   (CNT_W)
	) u_tx_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_restart (restart),
		.i_period  (period),
		.o_bit_tick(tick)
	);

	always_comb
	begin
		st_next = st_reg;
		st_next.dp_sync = {st_reg.dp_sync[0], i_dp};
		st_next.dm_sync = {st_reg.dm_sync[0], i_dm};
		st_next.ls_sync = {st_reg.ls_sync[0], i_ls_attached};
		st_next.ls_pol  = pol;
		st_next.rx_sop  = 1'b0;
		st_next.rx_eop  = 1'b0;
		st_next.rx_ka   = 1'b0;

		// Idle/Resume are just J/K at the receiver
		st_next.rx_j   = (line == LINE_DIFF1 && j_lvl) || (line == LINE_DIFF0 && !j_lvl);
		st_next.rx_k   = (line == LINE_DIFF0 && j_lvl) || (line == LINE_DIFF1 && !j_lvl);
		st_next.rx_se0 = (line == LINE_SE0);

		if (st_reg.rx_j && st_next.rx_k)
			st_next.rx_sop = 1'b1;

		// SE0 width counted against our own bit time; saturate to avoid wrap
		if (line == LINE_SE0)
		begin
			if (st_reg.se0_cnt != '1)
				st_next.se0_cnt = st_reg.se0_cnt + CNT_W'(1);
			if (st_reg.se0_cnt >= own_bit * CNT_W'(RX_SE0_MIN_BITS) - CNT_W'(1))
				st_next.se0_ok = 1'b1;
			st_next.se0_ls = pol;
		end
		else
		begin
			st_next.se0_cnt = '0;
			if (st_reg.se0_ok && st_next.rx_j)
			begin
				// On a low-speed segment every EOP is also the keep-alive form
				st_next.rx_eop = 1'b1;
				st_next.rx_ka  = st_reg.se0_ls;
			end
			st_next.se0_ok = 1'b0;
		end

		// Transmit EOP: two bits SE0 then one bit J, then release the line
		case (st_reg.tx_st)
			ULSC_IDLE:
			begin
				st_next.tx_oe   = 1'b0;
				st_next.tx_busy = 1'b0;
				st_next.tx_cnt  = '0;
				if (i_send_eop || i_send_keepalive)
				begin
					st_next.tx_ls   = i_send_keepalive | i_tx_ls_rate;
					st_next.tx_st   = ULSC_SE0;
					st_next.tx_oe   = 1'b1;
					st_next.tx_busy = 1'b1;
					st_next.tx_dp   = 1'b0;
					st_next.tx_dm   = 1'b0;
				end
			end
			ULSC_SE0:
			begin
				if (tick)
				begin
					if (st_reg.tx_cnt == CNT_W'(EOP_SE0_BITS - 1))
					begin
						st_next.tx_cnt = '0;
						st_next.tx_st  = ULSC_J;
						st_next.tx_dp  = j_lvl;
						st_next.tx_dm  = ~j_lvl;
						// J bit length follows the buffer speed, LS driver on LS segment
						// A full-speed buffer keeps a full-speed J even after an LS-rate or keep-alive SE0
						st_next.tx_ls  = pol;
					end
					else
						st_next.tx_cnt = st_reg.tx_cnt + CNT_W'(1);
				end
			end
			ULSC_J:
			begin
				if (tick && st_reg.tx_cnt == CNT_W'(EOP_J_BITS - 1))
				begin
					st_next.tx_st   = ULSC_IDLE;
					st_next.tx_oe   = 1'b0;
					st_next.tx_busy = 1'b0;
				end
			end
			default:
			begin
				st_next.tx_st = ULSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_reset_n)
			st_reg <= '{tx_st: ULSC_IDLE, default: '0};
		else
			st_reg <= st_next;
	end

	assign o_tx_dp        = st_reg.tx_dp;
	assign o_tx_dm        = st_reg.tx_dm;
	assign o_tx_oe        = st_reg.tx_oe;
	assign o_tx_busy      = st_reg.tx_busy;
	assign o_rx_j         = st_reg.rx_j;
	assign o_rx_k         = st_reg.rx_k;
	assign o_rx_se0       = st_reg.rx_se0;
	assign o_rx_sop       = st_reg.rx_sop;
	assign o_rx_eop       = st_reg.rx_eop;
	assign o_rx_keepalive = st_reg.rx_ka;
	assign o_ls_polarity  = st_reg.ls_pol;
endmodule // ulsc_line_state

// ==== tb/ulsc_line_state_assertions.sv ====
`timescale 1ns/1ps
module ulsc_line_state_assertions(
	input wire logic i_ref_clk,        // Clock
	input wire logic i_reset_n,        // Reset
	input wire logic i_hs_mode,        // HS mode
	input wire logic i_tx_ls_rate,     // LS rate
	input wire logic i_send_eop,       // EOP request
	input wire logic i_send_keepalive, // Keep-alive request
	input wire logic o_tx_dp,          // D+ drive
	input wire logic o_tx_dm,          // D- drive
	input wire logic o_tx_oe,          // Drive enable
	input wire logic o_tx_busy,        // Busy
	input wire logic o_ls_polarity     // LS sense
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	wire j_on = o_tx_dp ^ o_tx_dm;
	start_se0_a: assert property (i_send_eop && !o_tx_busy |=> o_tx_oe && !o_tx_dp && !o_tx_dm)
		else $error("EOP did not open with SE0");
	fs_se0_a: assert property ($rose(o_tx_oe) && !o_ls_polarity && !$past(i_tx_ls_rate) &&
		!$past(i_send_keepalive) |-> (!j_on)[*8] ##[13:15] j_on) else $error("FS SE0 length wrong");
	ls_se0_a: assert property ($rose(o_tx_oe) && ($past(i_tx_ls_rate) || $past(i_send_keepalive))
		|-> ##160 !j_on ##[5:9] j_on) else $error("LS SE0 length wrong");
	fs_tail_a: assert property ($rose(j_on) && o_tx_oe && !o_ls_polarity |-> o_tx_oe[*8] ##[2:4] !o_tx_oe)
		else $error("FS trailing J length wrong");
	ls_tail_a: assert property ($rose(j_on) && o_tx_oe && o_ls_polarity |-> ##78 o_tx_oe ##[3:7] !o_tx_oe)
		else $error("LS trailing J length wrong");
	fs_sense_a: assert property ($rose(j_on) && o_tx_oe && !o_ls_polarity |-> o_tx_dp)
		else $error("FS J not differential one");
	ls_sense_a: assert property ($rose(j_on) && o_tx_oe && o_ls_polarity |-> o_tx_dm)
		else $error("LS J not differential zero");
	hs_sense_a: assert property (i_hs_mode |=> !o_ls_polarity)
		else $error("LS sense in HS mode");
	cover property ($rose(o_tx_oe) && o_ls_polarity);
	cover property ($rose(o_tx_oe) && $past(i_send_keepalive));
	cover property ($rose(o_tx_oe) && $past(i_tx_ls_rate) && !o_ls_polarity);
endmodule // ulsc_line_state_assertions
bind ulsc_line_state ulsc_line_state_assertions chk(.i_ref_clk, .i_reset_n, .i_hs_mode, .i_tx_ls_rate,
	.i_send_eop, .i_send_keepalive, .o_tx_dp, .o_tx_dm, .o_tx_oe, .o_tx_busy, .o_ls_polarity);

// ==== tb/ulsc_far_dev.sv ====
`timescale 1ns/1ps
module ulsc_far_dev(
	input  wire logic i_ref_clk, // Clock
	input  wire logic i_ls,      // Low-speed device
	output logic      o_dp,      // D+ from device
	output logic      o_dm       // D- from device
);
	// Released line rests on the pull-up, which reads as J
	initial {o_dp, o_dm} = 2'h2;
	// s: 0 J, 1 K, 2 SE0, held n cycles
	task automatic drv(input int s, input int n);
		repeat (n)
		begin
			@(negedge i_ref_clk);
			{o_dp, o_dm} = (s == 2) ? 2'h0 : {s[0] ^ !i_ls, s[0] ^ i_ls};
		end
	endtask
endmodule // ulsc_far_dev

// ==== tb/ulsc_line_state_tb.sv ====
`timescale 1ns/1ps
module ulsc_line_state_tb;
	import ulsc_pkg::*;
	logic clk, rst_n, ls, hs, rate, seo, ska, tdp, tdm, toe, busy, rj, rk, rse0, sop, eop, kal, lsp, ddp, ddm;
	int   n_fail, n_tests, c_sop, c_eop, c_ka;
	ulsc_line_state dut(.i_ref_clk(clk), .i_reset_n(rst_n), .i_dp(toe ? tdp : ddp), .i_dm(toe ? tdm : ddm),
		.i_ls_attached(ls), .i_hs_mode(hs), .i_tx_ls_rate(rate), .i_send_eop(seo), .i_send_keepalive(ska),
		.o_tx_dp(tdp), .o_tx_dm(tdm), .o_tx_oe(toe), .o_tx_busy(busy), .o_rx_j(rj), .o_rx_k(rk),
		.o_rx_se0(rse0), .o_rx_sop(sop), .o_rx_eop(eop), .o_rx_keepalive(kal), .o_ls_polarity(lsp));
	ulsc_far_dev dev(.i_ref_clk(clk), .i_ls(ls), .o_dp(ddp), .o_dm(ddm));
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		c_sop += sop;
		c_eop += eop;
		c_ka += kal;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Sends one EOP or keep-alive and measures SE0 and J cycles while driven
	task automatic frame(input logic l, h, r, k, input int es, ej);
		int   s = 0, j = 0, w = 0, b = 0;
		logic jp = !(l && !h);
		ls = l;
		hs = h;
		rate = r;
		dev.drv(0, 8);
		chk("ls_polarity", l && !h, lsp);
		seo = !k;
		ska = k;
		@(negedge clk);
		ska = 0;
		while (toe === 1'h1 && w < 2000)
		begin
			s += (tdp === 1'h0 && tdm === 1'h0);
			j += ({tdp, tdm} === {jp, !jp});
			b += (busy === 1'h1);
			// A second request while busy must be dropped
			seo = (w == 2);
			w++;
			@(negedge clk);
		end
		if (w == 2000)
		begin
			n_fail++;
			results();
		end
		chk("se0_cycles", es, s);
		chk("j_cycles", ej, j);
		// Busy must cover the whole SE0 and trailing J, no more and no less
		chk("busy_cycles", es + ej, b);
		repeat (4) @(negedge clk);
		chk("busy_after", 0, busy);
	endtask
	task automatic t_tx_fs();
		frame(0, 0, 0, 0, 2 * FS_BIT_CYC + 1, FS_BIT_CYC);
		frame(0, 0, 1, 0, 2 * LS_BIT_CYC + 1, FS_BIT_CYC);
		frame(0, 0, 0, 1, 2 * LS_BIT_CYC + 1, FS_BIT_CYC);
	endtask
	task automatic t_tx_ls();
		frame(1, 0, 1, 0, 2 * LS_BIT_CYC + 1, LS_BIT_CYC);
		frame(1, 1, 0, 0, 2 * FS_BIT_CYC + 1, FS_BIT_CYC);
	endtask
	task automatic t_rx(input logic l);
		ls = l;
		hs = 0;
		dev.drv(0, 12);
		chk("rx_j", 1, rj);
		c_sop = 0;
		c_eop = 0;
		c_ka = 0;
		dev.drv(1, 12);
		chk("rx_k", 1, rk);
		// Shorter than the receiver's own bit time, so no EOP; on LS it still exceeds an FS bit
		dev.drv(2, l ? FS_BIT_CYC + 2 : 3);
		dev.drv(0, 12);
		dev.drv(1, 4);
		dev.drv(2, (l ? LS_BIT_CYC : FS_BIT_CYC) + 2);
		chk("rx_se0", 1, rse0);
		dev.drv(0, 12);
		chk("sop", 2, c_sop);
		chk("eop", 1, c_eop);
		chk("keepalive", l, c_ka);
	endtask
	initial
	begin
		{rst_n, ls, hs, rate, seo, ska} = 6'h0;
		{n_fail, n_tests, c_sop, c_eop, c_ka} = '0;
		repeat (12) @(negedge clk);
		rst_n = 1;
		t_tx_fs();
		t_tx_ls();
		t_rx(0);
		t_rx(1);
		results();
	end
endmodule // ulsc_line_state_tb
